// ### pkg/rtc_pkg.sv
// rtc_pkg: register map, field layout, counts and types of the real-time clock
package rtc_pkg;

    // ************************************************************
    // register byte offsets on the wishbone bus
    // ************************************************************
    localparam logic [7:0] ADR_TIME     = 8'h00;
    localparam logic [7:0] ADR_DAY      = 8'h04;
    localparam logic [7:0] ADR_ALM_TIME = 8'h08;
    localparam logic [7:0] ADR_ALM_DAY  = 8'h0C;
    localparam logic [7:0] ADR_SWATCH   = 8'h10;
    localparam logic [7:0] ADR_CTRL     = 8'h14;
    localparam logic [7:0] ADR_STAT     = 8'h18;

    // ************************************************************
    // field widths and positions
    // ************************************************************
    localparam int SEC_W  = 6;
    localparam int MIN_W  = 6;
    localparam int HOUR_W = 5;
    localparam int DAY_W  = 15;
    localparam int SW_W   = 16;
    localparam int SEC_LSB  = 0;
    localparam int MIN_LSB  = 8;
    localparam int HOUR_LSB = 16;

    // ************************************************************
    // counter limits and prescaler
    // ************************************************************
    localparam logic [SEC_W-1:0]  SEC_LAST  = 6'h3B;
    localparam logic [MIN_W-1:0]  MIN_LAST  = 6'h3B;
    localparam logic [HOUR_W-1:0] HOUR_LAST = 5'h17;
    localparam logic [DAY_W-1:0]  DAY_LAST  = 15'h7FFF;
    localparam int XTAL_HZ  = 32768;
    localparam int TICK_HZ  = 1;
    localparam int PRESC_W  = 15;
    localparam int PRESC_DIV = XTAL_HZ / TICK_HZ;
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(PRESC_DIV - 1);

    // ************************************************************
    // status flags; control bits 0..6 pass the flag of same index to irq; bits 0..2 also gate its event
    // ************************************************************
    localparam int FLG_ALM  = 0;
    localparam int FLG_DALM = 1;
    localparam int FLG_SW   = 2;
    localparam int FLG_SEC  = 3;
    localparam int FLG_MIN  = 4;
    localparam int FLG_HOUR = 5;
    localparam int FLG_DAY  = 6;
    localparam int NFLAG    = 7;
    localparam int CTRL_WAKE = 8;
    localparam int STAT_PEND = 8;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [8:0]      CTRL_RST = 9'h000;
    localparam logic [SW_W-1:0] SW_RST   = 16'h0000;

    typedef struct packed {
        logic [DAY_W-1:0]  day;
        logic [HOUR_W-1:0] hour;
        logic [MIN_W-1:0]  min;
        logic [SEC_W-1:0]  sec;
    } rtc_time_type;

endpackage

// ### verilog/rtc_wrap_cnt.sv
// rtc_wrap_cnt: loadable up counter that wraps to zero after a given last value
`timescale 1ns/1ps
`default_nettype none
module rtc_wrap_cnt #(
    parameter int         W    = 6,
    parameter logic [W-1:0] LAST = '1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // control
    input  wire logic         inc_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    // state
    output logic      [W-1:0] count_o,
    output logic              wrap_o
);

    logic [W-1:0] next_count;

    // a load beats the increment so a staged time is never lost to a tick
    always_comb begin
        next_count = count_o;
        if (load_i) begin
            next_count = load_val_i;
        end else if (inc_i) begin
            next_count = (count_o == LAST) ? '0 : count_o + W'(1);
        end
    end

    assign wrap_o = inc_i & ~load_i & (count_o == LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else begin
            count_o <= next_count;
        end
    end

endmodule // rtc_wrap_cnt
`default_nettype wire

// ### verilog/rtc_core.sv
// rtc_core: real-time clock with alarms, stopwatch and wakeup behind wishbone
`timescale 1ns/1ps
`default_nettype none
module rtc_core (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // crystal tick, one cycle per 32.768 kHz period
    input  wire logic        xtal_tick_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // events to the system
    output logic             irq_o,
    output logic             wake_o
);

    // ************************************************************
    // helper functions
    // ************************************************************
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] pack_tod(input rtc_pkg::rtc_time_type t);
        logic [31:0] res;
        res = 32'h0000_0000;
        res[rtc_pkg::SEC_LSB  +: rtc_pkg::SEC_W]  = t.sec;
        res[rtc_pkg::MIN_LSB  +: rtc_pkg::MIN_W]  = t.min;
        res[rtc_pkg::HOUR_LSB +: rtc_pkg::HOUR_W] = t.hour;
        return res;
    endfunction

    function automatic rtc_pkg::rtc_time_type unpack_tod(input logic [31:0] w,
                                                         input logic [14:0] day);
        rtc_pkg::rtc_time_type t;
        t.day  = day;
        t.sec  = w[rtc_pkg::SEC_LSB  +: rtc_pkg::SEC_W];
        t.min  = w[rtc_pkg::MIN_LSB  +: rtc_pkg::MIN_W];
        t.hour = w[rtc_pkg::HOUR_LSB +: rtc_pkg::HOUR_W];
        return t;
    endfunction

    // ************************************************************
    // bus decode
    // ************************************************************
    logic        bus_req;
    logic        wr_fire;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // writes land on the edge where the master sees ack
    assign wr_fire = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

    // ************************************************************
    // prescaler
    // ************************************************************
    logic [rtc_pkg::PRESC_W-1:0] presc;
    logic [rtc_pkg::PRESC_W-1:0] next_presc;
    logic                        sec_tick;
    logic                        tick_d;

    always_comb begin
        next_presc = presc;
        if (xtal_tick_i) begin
            next_presc = (presc == rtc_pkg::PRESC_LAST) ? '0 : presc + 15'h0001;
        end
    end

    assign sec_tick = xtal_tick_i & (presc == rtc_pkg::PRESC_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc  <= '0;
            tick_d <= 1'b0;
        end else begin
            presc  <= next_presc;
            tick_d <= sec_tick;
        end
    end

    // ************************************************************
    // staging of software writes onto the crystal tick
    // ************************************************************
    // loading mid-period would tear a running counter chain, so loads wait
    logic [31:0]               stg_tod;
    logic [rtc_pkg::DAY_W-1:0] stg_day;
    logic [rtc_pkg::SW_W-1:0]  stg_sw;
    logic [rtc_pkg::SW_W-1:0]  sw_cnt;
    logic                      pend_tod;
    logic                      pend_day;
    logic                      pend_sw;
    logic [31:0]               next_stg_tod;
    logic [rtc_pkg::DAY_W-1:0] next_stg_day;
    logic [rtc_pkg::SW_W-1:0]  next_stg_sw;
    logic                      next_pend_tod;
    logic                      next_pend_day;
    logic                      next_pend_sw;
    logic                      load_tod;
    logic                      load_day;
    logic                      load_sw;
    rtc_pkg::rtc_time_type     now;
    rtc_pkg::rtc_time_type     stg_time;

    assign load_tod = pend_tod & xtal_tick_i;
    assign load_day = pend_day & xtal_tick_i;
    assign load_sw  = pend_sw  & xtal_tick_i;
    assign stg_time = unpack_tod(stg_tod, stg_day);

    always_comb begin
        next_stg_tod  = stg_tod;
        next_stg_day  = stg_day;
        next_stg_sw   = stg_sw;
        next_pend_tod = pend_tod & ~load_tod;
        next_pend_day = pend_day & ~load_day;
        next_pend_sw  = pend_sw  & ~load_sw;
        if (wr_fire) begin
            case (wb_adr_i)
                rtc_pkg::ADR_TIME: begin
                    next_stg_tod  = merge_bytes(pack_tod(now), wb_dat_i, wb_sel_i);
                    next_pend_tod = 1'b1;
                end
                rtc_pkg::ADR_DAY: begin
                    next_stg_day  = rtc_pkg::DAY_W'(merge_bytes(32'(now.day), wb_dat_i,
                                                                wb_sel_i));
                    next_pend_day = 1'b1;
                end
                rtc_pkg::ADR_SWATCH: begin
                    next_stg_sw  = rtc_pkg::SW_W'(merge_bytes(32'(sw_cnt), wb_dat_i,
                                                              wb_sel_i));
                    next_pend_sw = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stg_tod  <= '0;
            stg_day  <= '0;
            stg_sw   <= '0;
            pend_tod <= 1'b0;
            pend_day <= 1'b0;
            pend_sw  <= 1'b0;
        end else begin
            stg_tod  <= next_stg_tod;
            stg_day  <= next_stg_day;
            stg_sw   <= next_stg_sw;
            pend_tod <= next_pend_tod;
            pend_day <= next_pend_day;
            pend_sw  <= next_pend_sw;
        end
    end

    // ************************************************************
    // timekeeping chain
    // ************************************************************
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;

    rtc_wrap_cnt #(.W(rtc_pkg::SEC_W), .LAST(rtc_pkg::SEC_LAST)) u_sec (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .inc_i      (sec_tick),
        .load_i     (load_tod),
        .load_val_i (stg_time.sec),
        .count_o    (now.sec),
        .wrap_o     (sec_wrap)
    );

    rtc_wrap_cnt #(.W(rtc_pkg::MIN_W), .LAST(rtc_pkg::MIN_LAST)) u_min (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .inc_i      (sec_wrap),
        .load_i     (load_tod),
        .load_val_i (stg_time.min),
        .count_o    (now.min),
        .wrap_o     (min_wrap)
    );

    rtc_wrap_cnt #(.W(rtc_pkg::HOUR_W), .LAST(rtc_pkg::HOUR_LAST)) u_hour (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .inc_i      (min_wrap),
        .load_i     (load_tod),
        .load_val_i (stg_time.hour),
        .count_o    (now.hour),
        .wrap_o     (hour_wrap)
    );

    rtc_wrap_cnt #(.W(rtc_pkg::DAY_W), .LAST(rtc_pkg::DAY_LAST)) u_day (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .inc_i      (hour_wrap),
        .load_i     (load_day),
        .load_val_i (stg_time.day),
        .count_o    (now.day),
        .wrap_o     ()
    );

    // ************************************************************
    // control, alarms and stopwatch
    // ************************************************************
    logic [8:0]                ctrl;
    logic [8:0]                next_ctrl;
    logic [31:0]               alm_tod;
    logic [31:0]               next_alm_tod;
    logic [rtc_pkg::DAY_W-1:0] alm_day;
    logic [rtc_pkg::DAY_W-1:0] next_alm_day;
    logic [rtc_pkg::SW_W-1:0]  next_sw_cnt;
    logic                      tod_match;
    logic [rtc_pkg::NFLAG-1:0] evt;

    always_comb begin
        next_ctrl    = ctrl;
        next_alm_tod = alm_tod;
        next_alm_day = alm_day;
        if (wr_fire) begin
            case (wb_adr_i)
                rtc_pkg::ADR_CTRL:     next_ctrl = 9'(merge_bytes(32'(ctrl), wb_dat_i,
                                                                  wb_sel_i));
                rtc_pkg::ADR_ALM_TIME: next_alm_tod = pack_tod(unpack_tod(
                                           merge_bytes(alm_tod, wb_dat_i, wb_sel_i),
                                           alm_day));
                rtc_pkg::ADR_ALM_DAY:  next_alm_day = rtc_pkg::DAY_W'(merge_bytes(
                                           32'(alm_day), wb_dat_i, wb_sel_i));
                default: begin
                end
            endcase
        end
    end

    // compared one cycle after the tick, once the chain has settled
    assign tod_match = (pack_tod(now) == alm_tod);

    always_comb begin
        next_sw_cnt = sw_cnt;
        evt         = '0;
        if (load_sw) begin
            next_sw_cnt = stg_sw;
        end else if (sec_tick & ctrl[rtc_pkg::FLG_SW]) begin
            next_sw_cnt = sw_cnt - 16'h0001;
            evt[rtc_pkg::FLG_SW] = (sw_cnt == '0);
        end
        evt[rtc_pkg::FLG_ALM]  = tick_d & ctrl[rtc_pkg::FLG_ALM] & tod_match;
        evt[rtc_pkg::FLG_DALM] = tick_d & ctrl[rtc_pkg::FLG_DALM] & tod_match
                                 & (now.day == alm_day);
        evt[rtc_pkg::FLG_SEC]  = sec_tick;
        evt[rtc_pkg::FLG_MIN]  = sec_wrap;
        evt[rtc_pkg::FLG_HOUR] = min_wrap;
        evt[rtc_pkg::FLG_DAY]  = hour_wrap;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl    <= rtc_pkg::CTRL_RST;
            alm_tod <= '0;
            alm_day <= '0;
            sw_cnt  <= rtc_pkg::SW_RST;
        end else begin
            ctrl    <= next_ctrl;
            alm_tod <= next_alm_tod;
            alm_day <= next_alm_day;
            sw_cnt  <= next_sw_cnt;
        end
    end

    // ************************************************************
    // sticky flags, interrupt and wakeup
    // ************************************************************
    logic [rtc_pkg::NFLAG-1:0] flags;
    logic [rtc_pkg::NFLAG-1:0] next_flags;
    logic [rtc_pkg::NFLAG-1:0] clr;
    logic                      next_irq;
    logic                      next_wake;

    assign clr = (wr_fire && wb_adr_i == rtc_pkg::ADR_STAT && wb_sel_i[0])
                 ? wb_dat_i[rtc_pkg::NFLAG-1:0] : '0;

    generate
        for (genvar i = 0; i < rtc_pkg::NFLAG; i++) begin : g_flag
            // set beats clear so an event in the clearing cycle survives
            assign next_flags[i] = evt[i] | (flags[i] & ~clr[i]);
        end
    endgenerate

    always_comb begin
        next_irq  = |(next_flags & ctrl[rtc_pkg::NFLAG-1:0]);
        // wake is a level for the power controller; it is registered on the core clock
        next_wake = next_irq & ctrl[rtc_pkg::CTRL_WAKE];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags  <= '0;
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            flags  <= next_flags;
            irq_o  <= next_irq;
            wake_o <= next_wake;
        end
    end

    // ************************************************************
    // wishbone answer
    // ************************************************************
    logic [31:0] next_rd;

    always_comb begin
        case (wb_adr_i)
            rtc_pkg::ADR_TIME:     next_rd = pack_tod(now);
            rtc_pkg::ADR_DAY:      next_rd = 32'(now.day);
            rtc_pkg::ADR_ALM_TIME: next_rd = alm_tod;
            rtc_pkg::ADR_ALM_DAY:  next_rd = 32'(alm_day);
            rtc_pkg::ADR_SWATCH:   next_rd = 32'(sw_cnt);
            rtc_pkg::ADR_CTRL:     next_rd = 32'(ctrl);
            rtc_pkg::ADR_STAT:     next_rd = 32'({(pend_tod | pend_day | pend_sw), 1'b0,
                                                  flags});
            default:               next_rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? next_rd : wb_dat_o;
        end
    end

endmodule // rtc_core
`default_nettype wire

// ### tb/rtc_xtal_model.sv
// rtc_xtal_model: crystal side, emits bursts of one-cycle ticks with a chosen spacing
`timescale 1ns/1ps
`default_nettype none
module rtc_xtal_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // burst request
    input  wire logic        start_i,
    input  wire logic [15:0] count_i,
    input  wire logic [3:0]  gap_i,
    // crystal tick
    output logic             tick_o,
    output logic             busy_o
);
    logic [15:0] left;
    logic [3:0]  wait_c;
    // a gap above zero models a slow crystal against the fast system clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left   <= 16'h0000;
            wait_c <= 4'h0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (start_i) begin
                left   <= count_i;
                wait_c <= gap_i;
            end else if (left != 16'h0000) begin
                if (wait_c == 4'h0) begin
                    tick_o <= 1'b1;
                    left   <= left - 16'h0001;
                    wait_c <= gap_i;
                end else begin
                    wait_c <= wait_c - 4'h1;
                end
            end
        end
    end
    assign busy_o = (left != 16'h0000) || tick_o;
endmodule // rtc_xtal_model
`default_nettype wire

// ### tb/rtc_core_checker.sv
// rtc_core_checker: port-level assertions for the real-time clock
`timescale 1ns/1ps
`default_nettype none
module rtc_core_checker (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        xtal_tick_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        irq_o,
    input  wire logic        wake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic mapped;
    assign mapped = wb_adr_i inside {rtc_pkg::ADR_TIME, rtc_pkg::ADR_DAY, rtc_pkg::ADR_ALM_TIME,
        rtc_pkg::ADR_ALM_DAY, rtc_pkg::ADR_SWATCH, rtc_pkg::ADR_CTRL, rtc_pkg::ADR_STAT};

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    wake_gated_a: assert property (wake_o |-> irq_o) else $error("wake without irq");
    irq_rise_a: assert property ($rose(irq_o) |-> $past(xtal_tick_i) || $past(xtal_tick_i, 2)
        || $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("irq rose without cause");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i)
        || $past(wb_ack_o && wb_we_i, 2)) else $error("irq fell without write");
    reset_quiet_a: assert property ($fell(rst_i) |-> !irq_o && !wake_o && !wb_ack_o
        && wb_dat_o == 32'h0) else $error("outputs not idle after reset");

    irq_seen_c: cover property ($rose(irq_o));
    wake_seen_c: cover property ($rose(wake_o));
    read_seen_c: cover property (wb_ack_o && !wb_we_i);
endmodule // rtc_core_checker
bind rtc_core rtc_core_checker rtc_core_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .xtal_tick_i(xtal_tick_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .wake_o(wake_o));
`default_nettype wire

// ### tb/rtc_core_bench.sv
// rtc_core_bench: self-checking bench for the real-time clock
`timescale 1ns/1ps
`default_nettype none
module rtc_core_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0, gap = 4'h0;
    logic [15:0] burst = 16'h0000;
    logic [31:0] wdat = 32'h0, dat_o, r;
    logic        ack, irq, wake, tick, busy;
    logic [31:0] exp_q[$];
    int          err_count = 0, checked = 0, cycles = 0;

    initial forever #12.5 clk_i = ~clk_i;

    rtc_xtal_model rtc_xtal_model_inst (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
        .count_i(burst), .gap_i(gap), .tick_o(tick), .busy_o(busy));
    rtc_core rtc_core_inst (.clk_i(clk_i), .rst_i(rst_i), .xtal_tick_i(tick), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq), .wake_o(wake));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic close_out();
        if (exp_q.size() != 0) err_count++;
        $display("errors %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] act, input logic [31:0] expv);
        checked++;
        if (act !== expv) begin
            err_count++;
            $display("Error at %0t: read %h expected %h", $time, act, expv);
        end
    endtask

    task automatic cmp_bit(input logic act, input logic expv);
        checked++;
        if (act !== expv) begin
            err_count++;
            $display("Error at %0t: event line %b expected %b", $time, act, expv);
        end
    endtask

    // ************************************************************
    // wishbone master: hold the request until ack is sampled
    // ************************************************************
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wb_read(input logic [7:0] a, input logic [31:0] expv);
        exp_q.push_back(expv);
        wb_xfer(1'b0, a, 32'h0, 4'hF);
    endtask

    task automatic run_ticks(input logic [15:0] n, input logic [3:0] g);
        @(posedge clk_i);
        burst <= n;
        gap   <= g;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        do @(posedge clk_i); while (busy !== 1'b0);
        repeat (4) @(posedge clk_i);
    endtask

    task automatic chk_events(input logic i, input logic w);
        repeat (3) @(posedge clk_i);
        cmp_bit(irq, i);
        cmp_bit(wake, w);
    endtask

    // ************************************************************
    // read results leave in order, so the oldest note matches
    // ************************************************************
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("Error at %0t: read with no expected value", $time);
            end else begin
                cmp_word(dat_o, exp_q.pop_front());
            end
        end
    end

    // run is about 66k cycles; the ceiling leaves margin
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        r = lfsr(32'hBFE1B2C7);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_read(rtc_pkg::ADR_CTRL, 32'h0);
        wb_read(rtc_pkg::ADR_STAT, 32'h0);
        wb_xfer(1'b1, rtc_pkg::ADR_ALM_DAY, r, 4'hF);
        wb_read(rtc_pkg::ADR_ALM_DAY, {17'h0, r[14:0]});
        r = lfsr(r);
        wb_xfer(1'b1, 8'h1C, r, 4'hF);
        wb_read(8'h1C, 32'h0);
        wb_xfer(1'b1, rtc_pkg::ADR_ALM_TIME, 32'h0, 4'hF);
        wb_xfer(1'b1, rtc_pkg::ADR_ALM_DAY, 32'h1, 4'hF);
        wb_xfer(1'b1, rtc_pkg::ADR_TIME, 32'h00173B3B, 4'hF);
        wb_xfer(1'b1, rtc_pkg::ADR_DAY, 32'h7FFF, 4'hF);
        wb_xfer(1'b1, rtc_pkg::ADR_SWATCH, 32'h0, 4'hF);
        wb_read(rtc_pkg::ADR_STAT, 32'h100);
        wb_xfer(1'b1, rtc_pkg::ADR_CTRL, 32'h17F, 4'hF);
        // one tick short of a full second; the tail runs on a slow crystal
        run_ticks(16'h7F00, 4'h0);
        run_ticks(16'h00FF, 4'h1);
        wb_read(rtc_pkg::ADR_STAT, 32'h0);
        wb_read(rtc_pkg::ADR_TIME, 32'h00173B3B);
        wb_read(rtc_pkg::ADR_DAY, 32'h7FFF);
        chk_events(1'b0, 1'b0);
        run_ticks(16'h0001, 4'h0);
        wb_read(rtc_pkg::ADR_TIME, 32'h0);
        wb_read(rtc_pkg::ADR_DAY, 32'h0);
        wb_read(rtc_pkg::ADR_SWATCH, 32'hFFFF);
        wb_read(rtc_pkg::ADR_STAT, 32'h7D);
        chk_events(1'b1, 1'b1);
        wb_xfer(1'b1, rtc_pkg::ADR_CTRL, 32'h107, 4'hF);
        chk_events(1'b1, 1'b1);
        wb_xfer(1'b1, rtc_pkg::ADR_STAT, 32'h05, 4'h1);
        chk_events(1'b0, 1'b0);
        wb_xfer(1'b1, rtc_pkg::ADR_STAT, 32'h78, 4'hE);
        wb_read(rtc_pkg::ADR_STAT, 32'h78);
        wb_xfer(1'b1, rtc_pkg::ADR_CTRL, 32'h078, 4'hF);
        chk_events(1'b1, 1'b0);
        wb_xfer(1'b1, rtc_pkg::ADR_STAT, 32'h78, 4'h1);
        chk_events(1'b0, 1'b0);
        wb_read(rtc_pkg::ADR_STAT, 32'h0);
        // both alarms aim at 00:00:01 of day 0, one full second later
        wb_xfer(1'b1, rtc_pkg::ADR_ALM_TIME, 32'h1, 4'hF);
        wb_xfer(1'b1, rtc_pkg::ADR_ALM_DAY, 32'h0, 4'hF);
        wb_xfer(1'b1, rtc_pkg::ADR_CTRL, 32'h103, 4'hF);
        run_ticks(16'h8000, 4'h0);
        wb_read(rtc_pkg::ADR_TIME, 32'h1);
        wb_read(rtc_pkg::ADR_SWATCH, 32'hFFFF);
        wb_read(rtc_pkg::ADR_STAT, 32'h0B);
        chk_events(1'b1, 1'b1);
        repeat (4) @(posedge clk_i);
        close_out();
    end
endmodule // rtc_core_bench
`default_nettype wire
